// file: src/bridge_arb_regs.svh
`ifndef BRIDGE_ARB_REGS_SVH
`define BRIDGE_ARB_REGS_SVH
// Cycles the upstream request stays withdrawn after retry, disconnect or abort
`define UP_BACKOFF_CYCLES 2'h2
// Cycles from downstream device select until the posted write is armed; the request follows one cycle later
`define UP_POST_LAG 3'h3
// Idle cycles a granted master may leave the bus unstarted
`define DN_GNT_TIMEOUT 16
// Priority groups after reset: the bridge (bit 9) high, external masters low
`define PRIO_RESET 10'h200
// Arbiter index of the bridge itself
`define DEV_IDX 4'h9
// Rotation slot that stands for the whole low group
`define LOW_SLOT 4'ha
// Slots in the high-group rotation
`define SLOT_COUNT 5'h0b
`endif

// file: src/bridge_arb_pkg.sv
`default_nettype none
package bridge_arb_pkg;
    typedef enum logic [3:0] {
        UP_IDLE    = 4'h1,
        UP_REQ     = 4'h2,
        UP_MASTER  = 4'h4,
        UP_BACKOFF = 4'h8
    } up_state_type;
    typedef enum logic [1:0] {
        DN_HOLD = 2'h1,
        DN_GAP  = 2'h2
    } dn_state_type;
endpackage
`default_nettype wire

// file: src/bridge_bus_arbitration.sv
`timescale 1ns/1ps
`default_nettype none
`include "bridge_arb_regs.svh"

module bridge_bus_arbitration #(
    parameter int TIMEOUT = `DN_GNT_TIMEOUT
) (
    input  wire logic       i_clock,
    input  wire logic       i_sys_rst,
    input  wire logic       i_down_arbiter_strap_n,
    input  wire logic       i_up_post_pending,
    input  wire logic       i_up_dly_queued,
    input  wire logic       i_up_dly_retried,
    input  wire logic       i_up_dly_head,
    input  wire logic       i_down_device_select_n,
    input  wire logic       i_up_gnt_n,
    input  wire logic       i_up_frame_n,
    input  wire logic       i_up_irdy_n,
    input  wire logic       i_up_term_backoff,
    input  wire logic       i_up_done,
    output logic            o_up_req_n,
    output logic            o_up_start,
    output logic            o_up_park_ad_oe,
    output logic            o_up_park_par_oe,
    input  wire logic [8:0] i_down_req_n,
    input  wire logic       i_down_frame_n,
    input  wire logic       i_down_initiator_ready_n,
    input  wire logic       i_down_want,
    input  wire logic       i_down_done,
    input  wire logic       i_prio_load,
    input  wire logic [9:0] i_prio_cfg,
    output logic [8:0]      o_down_gnt_n,
    output logic            o_down_start,
    output logic            o_down_park_ad_oe,
    output logic            o_down_park_par_oe
);

    // Round-robin search: first set bit of m at or after s, modulo slot count
    function automatic logic [4:0] rr_pick(input logic [10:0] m, input logic [3:0] s);
        logic [4:0] r;
        logic [4:0] t;
        r = 5'h00;
        for (int i = 10; i >= 0; i--) begin
            t = {1'b0, s} + 5'(i);
            if (t >= `SLOT_COUNT) begin
                t = t - `SLOT_COUNT;
            end
            if (m[t[3:0]]) begin
                r = {1'b1, t[3:0]};
            end
        end
        return r;
    endfunction

    // Both buses share one clock in this build
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_sys_rst);

    bridge_arb_pkg::up_state_type up_state;
    bridge_arb_pkg::up_state_type next_up_state;
    bridge_arb_pkg::dn_state_type dn_state;
    bridge_arb_pkg::dn_state_type next_dn_state;
    logic       ext_mode;
    logic [2:0] post_lag;
    logic       post_armed;
    logic [1:0] backoff;
    logic [1:0] next_backoff;
    logic       up_want;
    logic       up_idle;
    logic       up_park;
    logic [9:0] prio;
    logic [3:0] hptr;
    logic [3:0] lptr;
    logic [3:0] owner;
    logic [3:0] next_owner;
    logic [9:0] skip;
    logic       frame_q;
    logic       frame_fall;
    logic       dn_idle;
    logic       dn_active;
    logic [4:0] tmo_cnt;
    logic       tmo_run;
    logic       tmo_hit;
    logic [9:0] reqv;
    logic [4:0] hp;
    logic [4:0] lp;
    logic       win_found;
    logic [3:0] win;
    logic       own_gnt;
    logic       own_req;
    logic       dn_start;
    logic       dn_park;

    // Strap sampled while reset is held
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            ext_mode <= i_down_arbiter_strap_n;
        end
    end

    // Posted write becomes eligible a few cycles after device select
    always_ff @(posedge i_clock) begin
        if (i_sys_rst || !i_up_post_pending) begin
            post_lag   <= 3'h0;
            post_armed <= 1'b0;
        end else if (!post_armed && (post_lag != 3'h0 || !i_down_device_select_n)) begin
            if (post_lag == `UP_POST_LAG) begin
                post_armed <= 1'b1;
            end else begin
                post_lag <= post_lag + 3'h1;
            end
        end
    end

    // Upstream work and bus state
    assign up_want = (i_up_post_pending && post_armed)
                   || (i_up_dly_queued && i_up_dly_retried && i_up_dly_head);
    assign up_idle = i_up_frame_n && i_up_irdy_n;
    assign up_park = !i_up_gnt_n && o_up_req_n && up_idle
                   && up_state != bridge_arb_pkg::UP_MASTER;

    // Upstream request sequencing
    always_comb begin
        next_up_state = up_state;
        next_backoff  = backoff;
        case (up_state)
            bridge_arb_pkg::UP_IDLE: begin
                if (up_want && o_up_park_ad_oe && !i_up_gnt_n && up_idle) begin
                    next_up_state = bridge_arb_pkg::UP_MASTER;
                end else if (up_want) begin
                    next_up_state = bridge_arb_pkg::UP_REQ;
                end
            end
            bridge_arb_pkg::UP_REQ: begin
                if (!up_want) begin
                    next_up_state = bridge_arb_pkg::UP_IDLE;
                end else if (!i_up_gnt_n && !o_up_req_n && up_idle) begin
                    next_up_state = bridge_arb_pkg::UP_MASTER;
                end
            end
            bridge_arb_pkg::UP_MASTER: begin
                if (i_up_term_backoff) begin
                    next_up_state = bridge_arb_pkg::UP_BACKOFF;
                    next_backoff  = `UP_BACKOFF_CYCLES - 2'h1;
                end else if (i_up_done) begin
                    next_up_state = up_want ? bridge_arb_pkg::UP_REQ : bridge_arb_pkg::UP_IDLE;
                end
            end
            bridge_arb_pkg::UP_BACKOFF: begin
                if (backoff == 2'h0) begin
                    next_up_state = up_want ? bridge_arb_pkg::UP_REQ : bridge_arb_pkg::UP_IDLE;
                end else begin
                    next_backoff = backoff - 2'h1;
                end
            end
            default: begin
                next_up_state = bridge_arb_pkg::UP_IDLE;
            end
        endcase
    end

    // Upstream state and request pin
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            up_state   <= bridge_arb_pkg::UP_IDLE;
            backoff    <= 2'h0;
            o_up_req_n <= 1'b1;
            o_up_start <= 1'b0;
        end else begin
            up_state   <= next_up_state;
            backoff    <= next_backoff;
            o_up_req_n <= !(next_up_state == bridge_arb_pkg::UP_REQ
                          || (next_up_state == bridge_arb_pkg::UP_MASTER && up_want));
            o_up_start <= up_state != bridge_arb_pkg::UP_MASTER
                       && next_up_state == bridge_arb_pkg::UP_MASTER;
        end
    end

    // Upstream parking drivers, parity one cycle behind
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_up_park_ad_oe  <= 1'b0;
            o_up_park_par_oe <= 1'b0;
        end else begin
            o_up_park_ad_oe  <= up_park;
            o_up_park_par_oe <= up_park && o_up_park_ad_oe;
        end
    end

    // Downstream bus state and requests
    assign dn_idle    = i_down_frame_n && i_down_initiator_ready_n;
    assign frame_fall = frame_q && !i_down_frame_n;
    assign own_gnt    = ext_mode ? !i_down_req_n[0]
                      : (dn_state == bridge_arb_pkg::DN_HOLD && owner == `DEV_IDX);
    assign own_req    = ext_mode ? !o_down_gnt_n[0] : i_down_want;
    assign dn_start   = own_gnt && own_req && i_down_want && dn_idle && !dn_active;
    assign dn_park    = own_gnt && !own_req && dn_idle && !dn_active;
    assign reqv       = {i_down_want, ~i_down_req_n} & ~skip;
    assign tmo_run    = dn_state == bridge_arb_pkg::DN_HOLD && dn_idle && !ext_mode
                      && (owner == `DEV_IDX ? i_down_want : !i_down_req_n[owner]);
    assign tmo_hit    = tmo_run && tmo_cnt == 5'(TIMEOUT - 1);

    // Two-level winner: high group plus one slot for the low group
    always_comb begin
        hp        = rr_pick({|(reqv & ~prio), reqv & prio}, hptr);
        lp        = rr_pick({1'b0, reqv & ~prio}, lptr);
        win_found = hp[4];
        win       = (hp[3:0] == `LOW_SLOT) ? lp[3:0] : hp[3:0];
    end

    // Grant hand-over
    always_comb begin
        next_dn_state = dn_state;
        next_owner    = owner;
        case (dn_state)
            bridge_arb_pkg::DN_HOLD: begin
                if (tmo_hit) begin
                    next_dn_state = bridge_arb_pkg::DN_GAP;
                    next_owner    = `DEV_IDX;
                end else if (win_found && win != owner) begin
                    next_owner = win;
                    if (dn_idle) begin
                        next_dn_state = bridge_arb_pkg::DN_GAP;
                    end
                end
            end
            bridge_arb_pkg::DN_GAP: begin
                next_dn_state = bridge_arb_pkg::DN_HOLD;
                if (win_found) begin
                    next_owner = win;
                end
            end
            default: begin
                next_dn_state = bridge_arb_pkg::DN_HOLD;
            end
        endcase
    end

    // Arbiter state; grant parks on the last owner
    always_ff @(posedge i_clock) begin
        if (i_sys_rst || ext_mode) begin
            dn_state <= bridge_arb_pkg::DN_HOLD;
            owner    <= `DEV_IDX;
        end else begin
            dn_state <= next_dn_state;
            owner    <= next_owner;
        end
    end

    // Grant pins: internal decode or external-mode request
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_down_gnt_n <= 9'h1ff;
        end else if (ext_mode) begin
            o_down_gnt_n <= {8'hff, !(i_down_want && !dn_active)};
        end else begin
            for (int i = 0; i < 9; i++) begin
                o_down_gnt_n[i] <= !(next_dn_state == bridge_arb_pkg::DN_HOLD
                                  && next_owner == 4'(i));
            end
        end
    end

    // Priority groups
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            prio <= `PRIO_RESET;
        end else if (i_prio_load) begin
            prio <= i_prio_cfg;
        end
    end

    // Rotation pointers move at each frame start, except in external-arbiter mode
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            frame_q <= 1'b1;
            hptr    <= 4'h0;
            lptr    <= 4'h0;
        end else begin
            frame_q <= i_down_frame_n;
            if (frame_fall && !ext_mode) begin
                if (prio[owner]) begin
                    hptr <= owner + 4'h1;
                end else begin
                    hptr <= 4'h0;
                    lptr <= (owner == `DEV_IDX) ? 4'h0 : owner + 4'h1;
                end
            end
        end
    end

    // Grant timeout counter and skip mask for timed-out masters
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            tmo_cnt <= 5'h00;
            skip    <= 10'h000;
        end else begin
            tmo_cnt <= (tmo_run && !tmo_hit) ? tmo_cnt + 5'h01 : 5'h00;
            if (frame_fall) begin
                skip <= 10'h000;
            end else if (tmo_hit) begin
                skip[owner] <= 1'b1;
            end
        end
    end

    // Own downstream transaction start
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_down_start <= 1'b0;
            dn_active    <= 1'b0;
        end else begin
            o_down_start <= dn_start;
            if (dn_start) begin
                dn_active <= 1'b1;
            end else if (i_down_done) begin
                dn_active <= 1'b0;
            end
        end
    end

    // Downstream parking drivers, parity one cycle behind
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_down_park_ad_oe  <= 1'b0;
            o_down_park_par_oe <= 1'b0;
        end else begin
            o_down_park_ad_oe  <= dn_park;
            o_down_park_par_oe <= dn_park && o_down_park_ad_oe;
        end
    end

    req_held_a: assert property (up_state == bridge_arb_pkg::UP_REQ |-> !o_up_req_n)
        else $error("upstream request dropped while requesting");
    backoff_two_a: assert property ((up_state == bridge_arb_pkg::UP_MASTER && i_up_term_backoff)
        |=> o_up_req_n [*2])
        else $error("request not withdrawn for two cycles");
    post_lag_a: assert property ($rose(post_armed) |-> $past(i_up_post_pending, 4))
        else $error("posted write armed too early");
    up_start_a: assert property ((up_state == bridge_arb_pkg::UP_REQ && !i_up_gnt_n && !o_up_req_n
        && up_idle && up_want) |=> o_up_start)
        else $error("no start after upstream grant");
    start_gnt_a: assert property (o_up_start |-> $past(!i_up_gnt_n))
        else $error("start without prior grant");
    up_park_a: assert property (o_up_park_ad_oe |-> $past(!i_up_gnt_n && o_up_req_n && up_idle))
        else $error("upstream parked without grant or idle");
    up_float_a: assert property ((o_up_park_ad_oe && i_up_gnt_n) |=> !o_up_park_ad_oe)
        else $error("upstream drivers kept after grant loss");
    par_lag_a: assert property ($rose(o_up_park_par_oe) |-> $past(o_up_park_ad_oe))
        else $error("upstream parity driven too early");
    gnt_single_a: assert property (!ext_mode |-> $onehot0(~o_down_gnt_n))
        else $error("more than one downstream grant");
    idle_gap_a: assert property ((!ext_mode && $past(dn_idle) && $past(!ext_mode))
        |-> !(|($past(o_down_gnt_n) & ~o_down_gnt_n) && |(~$past(o_down_gnt_n) & o_down_gnt_n)))
        else $error("grant swapped on idle bus");
    gnt_timeout_a: assert property ((tmo_hit && owner != `DEV_IDX) |=> o_down_gnt_n == 9'h1ff)
        else $error("grant kept past timeout");
    ext_unused_a: assert property (ext_mode |=> o_down_gnt_n[8:1] == 8'hff)
        else $error("unused grant driven low");
    ext_park_a: assert property ((ext_mode && o_down_park_ad_oe)
        |-> $past(!i_down_req_n[0] && o_down_gnt_n[0] && dn_idle))
        else $error("downstream parked without external grant");

endmodule
`default_nettype wire

// file: verif/far_arbiter_model.sv
`timescale 1ns/1ps
`default_nettype none
// Far-side arbiter: grants the bridge one edge after it sees a request
module far_arbiter_model (
    input  wire logic i_clock,
    input  wire logic i_sys_rst,
    input  wire logic i_req_n,
    input  wire logic i_enable,
    input  wire logic i_park,
    output logic      o_gnt_n
);
    // Registered active-low grant; a parked grant needs no request
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_gnt_n <= 1'h1;
        end else begin
            o_gnt_n <= !(i_enable && (!i_req_n || i_park));
        end
    end
endmodule
`default_nettype wire

// file: verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int TO = 16;
    logic       clock = 1'h0;
    logic       rst = 1'h1;
    logic       strap_n = 1'h0;
    logic       post = 1'h0;
    logic       dq = 1'h0;
    logic       dr = 1'h0;
    logic       dh = 1'h0;
    logic       dsel_n = 1'h1;
    logic       up_frame_n = 1'h1;
    logic       up_irdy_n = 1'h1;
    logic       backoff = 1'h0;
    logic       up_done = 1'h0;
    logic [8:0] dn_req = 9'h1ff;
    logic       dn_frame_n = 1'h1;
    logic       dn_irdy_n = 1'h1;
    logic       dn_want = 1'h0;
    logic       dn_done = 1'h0;
    logic       prio_load = 1'h0;
    logic [9:0] prio_cfg = 10'h200;
    logic       arb_en = 1'h1;
    logic       up_park = 1'h0;
    logic       dn_park = 1'h0;
    int         fails = 0;
    int         check_count = 0;
    wire logic       up_gnt_n;
    wire logic       ext_gnt_n;
    wire logic [8:0] dn_req_pin;
    logic            up_req_n;
    logic            up_start;
    logic            up_ad;
    logic            up_par;
    logic [8:0]      dn_gnt_n;
    logic            dn_start;
    logic            dn_ad;
    logic            dn_par;

    // Board pulls unused request pins high in external mode
    assign dn_req_pin = strap_n ? {8'hff, ext_gnt_n} : dn_req;

    always #5 clock = ~clock;

    bridge_bus_arbitration #(.TIMEOUT(TO)) uut (
        .i_clock(clock), .i_sys_rst(rst), .i_down_arbiter_strap_n(strap_n),
        .i_up_post_pending(post), .i_up_dly_queued(dq), .i_up_dly_retried(dr),
        .i_up_dly_head(dh), .i_down_device_select_n(dsel_n), .i_up_gnt_n(up_gnt_n),
        .i_up_frame_n(up_frame_n), .i_up_irdy_n(up_irdy_n), .i_up_term_backoff(backoff),
        .i_up_done(up_done), .o_up_req_n(up_req_n), .o_up_start(up_start),
        .o_up_park_ad_oe(up_ad), .o_up_park_par_oe(up_par), .i_down_req_n(dn_req_pin),
        .i_down_frame_n(dn_frame_n), .i_down_initiator_ready_n(dn_irdy_n),
        .i_down_want(dn_want), .i_down_done(dn_done), .i_prio_load(prio_load),
        .i_prio_cfg(prio_cfg), .o_down_gnt_n(dn_gnt_n), .o_down_start(dn_start),
        .o_down_park_ad_oe(dn_ad), .o_down_park_par_oe(dn_par));

    // Upstream arbiter and external downstream arbiter
    far_arbiter_model up_arb (.i_clock(clock), .i_sys_rst(rst), .i_req_n(up_req_n),
        .i_enable(arb_en), .i_park(up_park), .o_gnt_n(up_gnt_n));
    far_arbiter_model dn_arb (.i_clock(clock), .i_sys_rst(rst), .i_req_n(dn_gnt_n[0]),
        .i_enable(arb_en), .i_park(dn_park), .o_gnt_n(ext_gnt_n));

    task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic do_reset(input logic s);
        strap_n = s;
        rst = 1'h1;
        tick(5);
        rst = 1'h0;
    endtask

    task automatic pulse_up_done();
        up_done = 1'h1;
        tick(1);
        up_done = 1'h0;
    endtask

    // Delayed request, grant, start, backoff and release
    task automatic test_upstream();
        int n;
        {dq, dr, dh} = 3'h7;
        for (n = 0; n < 10 && up_start !== 1'h1; n++) tick(1);
        check("up_start", up_start, 1'h1);
        check("up_req_n", up_req_n, 1'h0);
        tick(1);
        check("up_start_pulse", up_start, 1'h0);
        backoff = 1'h1;
        tick(1);
        backoff = 1'h0;
        n = 0;
        repeat (6) begin
            if (up_req_n === 1'h1) n++;
            tick(1);
        end
        check("backoff_len", n, 10'h2);
        {dq, dr, dh} = 3'h0;
        pulse_up_done();
        tick(4);
        check("up_req_idle", up_req_n, 1'h1);
        // Posted write waits some cycles after device select
        post = 1'h1;
        dsel_n = 1'h0;
        tick(1);
        dsel_n = 1'h1;
        tick(1);
        check("post_lag", up_req_n, 1'h1);
        for (n = 0; n < 10 && up_req_n !== 1'h0; n++) tick(1);
        check("post_req", up_req_n, 1'h0);
        post = 1'h0;
        tick(3);
        pulse_up_done();
        tick(3);
        check("post_idle", up_req_n, 1'h1);
    endtask

    // Parking upstream, start from park, float on grant loss
    task automatic test_up_park();
        int n;
        up_park = 1'h1;
        for (n = 0; n < 10 && up_ad !== 1'h1; n++) tick(1);
        check("up_ad_oe", up_ad, 1'h1);
        check("up_par_first", up_par, 1'h0);
        tick(1);
        check("up_par_oe", up_par, 1'h1);
        {dq, dr, dh} = 3'h7;
        for (n = 0; n < 10 && up_start !== 1'h1; n++) tick(1);
        check("park_start", up_start, 1'h1);
        check("park_lag", n, 10'h1);
        {dq, dr, dh} = 3'h0;
        pulse_up_done();
        tick(3);
        up_park = 1'h0;
        tick(3);
        check("up_float", {up_ad, up_par}, 10'h0);
    endtask

    // Own downstream start from the reset park, no pin used
    task automatic test_dn_own();
        int n;
        check("dn_self_park", {dn_ad, dn_par}, 10'h3);
        dn_want = 1'h1;
        for (n = 0; n < 6 && dn_start !== 1'h1; n++) tick(1);
        check("dn_own_start", dn_start, 1'h1);
        check("dn_own_pins", dn_gnt_n, 9'h1ff);
        dn_want = 1'h0;
        dn_done = 1'h1;
        tick(1);
        dn_done = 1'h0;
        tick(2);
    endtask

    // Gap before the new grant, then grant timeout
    task automatic test_dn_timeout();
        int n;
        dn_req[3] = 1'h0;
        tick(1);
        check("dn_gap", dn_gnt_n, 9'h1ff);
        for (n = 0; n < 5 && dn_gnt_n[3] !== 1'h0; n++) tick(1);
        check("dn_gnt3", dn_gnt_n, 9'h1f7);
        n = 0;
        while (n < 40 && dn_gnt_n[3] === 1'h0) begin
            n++;
            tick(1);
        end
        check("dn_timeout", n >= TO && n <= TO + 1, 1'h1);
        dn_req = 9'h1ff;
        tick(2);
    endtask

    // Plain rotation: the initiator yields to the other requester
    task automatic test_dn_rotate();
        logic [8:0] g;
        int         n;
        prio_cfg = 10'h3ff;
        prio_load = 1'h1;
        tick(1);
        prio_load = 1'h0;
        dn_req[2:1] = 2'h0;
        for (n = 0; n < 10 && dn_gnt_n === 9'h1ff; n++) tick(1);
        g = dn_gnt_n;
        check("dn_one_of", g === 9'h1fd || g === 9'h1fb, 1'h1);
        dn_frame_n = 1'h0;
        dn_irdy_n = 1'h0;
        tick(2);
        dn_frame_n = 1'h1;
        dn_irdy_n = 1'h1;
        for (n = 0; n < 6 && dn_gnt_n !== (g ^ 9'h006); n++) tick(1);
        check("dn_rotate", dn_gnt_n, g ^ 9'h006);
        dn_req = 9'h1ff;
        tick(3);
    endtask

    // External arbiter mode: request, start and park
    task automatic test_external();
        int n;
        do_reset(1'h1);
        dn_want = 1'h1;
        for (n = 0; n < 6 && dn_gnt_n[0] !== 1'h0; n++) tick(1);
        check("ext_req", dn_gnt_n, 9'h1fe);
        for (n = 0; n < 6 && dn_start !== 1'h1; n++) tick(1);
        check("ext_start", dn_start, 1'h1);
        dn_want = 1'h0;
        dn_done = 1'h1;
        tick(1);
        dn_done = 1'h0;
        dn_park = 1'h1;
        for (n = 0; n < 10 && dn_ad !== 1'h1; n++) tick(1);
        check("dn_ad_oe", dn_ad, 1'h1);
        check("dn_par_first", dn_par, 1'h0);
        tick(1);
        check("dn_par_oe", dn_par, 1'h1);
    endtask

    task automatic conclude();
        if (fails == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        do_reset(1'h0);
        check("rst_gnt", dn_gnt_n, 9'h1ff);
        check("rst_req", up_req_n, 1'h1);
        test_upstream();
        test_up_park();
        test_dn_own();
        test_dn_timeout();
        test_dn_rotate();
        test_external();
        conclude();
    end

    // Watchdog well beyond the hundred or so cycles of the run
    initial begin
        #50000;
        fails++;
        conclude();
    end
endmodule
`default_nettype wire
